/* acrt_cfg.svh */
// register offsets, field positions, reset values and full scale value
// assumes: included by bare name, defines only
//
// What this block does
// - interrupt needs enable bit and global bit
// - prescaler code selects system clock divide
// - right adjust: low byte, two high bits
// - left adjust: high byte, top two low
// - low read freezes result until high read
// - left adjust change shows immediately
// - unipolar result saturates when input negative
// - bipolar result is two's complement
// - reserved bit three stores written value
// - trigger select ignored without auto trigger
// - rising edge of source starts conversion
// - reselecting to set source is edge
// - selecting free running makes no edge
// - trigger source code table decode
// - disable bit kills buffer, pin reads zero
// - done flag set on update, cleared
// - auto trigger enable bit in control a
`ifndef ACRT_CFG_SVH
`define ACRT_CFG_SVH

// register indices; byte address is four times the index
`define ACRT_IDX_DIDR 6'h01
`define ACRT_IDX_CTLB 6'h03
`define ACRT_IDX_RESL 6'h04
`define ACRT_IDX_RESH 6'h05
`define ACRT_IDX_CTLA 6'h06

// control a fields
`define ACRT_A_EN 7
`define ACRT_A_START 6
`define ACRT_A_ATE 5
`define ACRT_A_FLAG 4
`define ACRT_A_IE 3
`define ACRT_A_PS_HI 2
`define ACRT_A_PS_LO 0

// control b fields
`define ACRT_B_BIN 7
`define ACRT_B_COMPARATOR_MUX_ENABLE 6
`define ACRT_B_LAR 4
`define ACRT_B_TS_HI 2
`define ACRT_B_TS_LO 0

// reset values
`define ACRT_RST_CTLA 8'h00
`define ACRT_RST_CTLB 8'h00
`define ACRT_RST_DIDR 8'h00
`define ACRT_RST_RES 10'h000

// full scale value used for unipolar saturation
`define ACRT_FULL_SCALE 10'h3FF

`endif

/* acrt_pkg.sv */
// types shared by the converter control block
// assumes: compiled before acrt_top
package acrt_pkg;

    typedef enum logic [2:0]
    {
        ACRT_TS_FREE,
        ACRT_TS_COMP,
        ACRT_TS_EXT0,
        ACRT_TS_T0_CMPA,
        ACRT_TS_T0_OVF,
        ACRT_TS_T1_CMPB,
        ACRT_TS_T1_OVF,
        ACRT_TS_T1_CAP
    } acrt_trig_e;

    typedef struct packed
    {
        logic comparator;
        logic ext_int0;
        logic t0_cmp_a;
        logic t0_ovf;
        logic t1_cmp_b;
        logic t1_ovf;
        logic t1_capture;
    } acrt_trig_s;

    typedef struct packed
    {
        logic done;
        logic negative;
        logic [9:0] magnitude;
    } acrt_conv_s;

endpackage : acrt_pkg

/* acrt_top.sv */
// converter control, result registers and auto trigger behind an apb slave
// assumes: analog core reports done with magnitude and sign on pclk;
// trigger flags come from logic on pclk; pin_in comes from pads
`timescale 1ns/10ps
`include "acrt_cfg.svh"

module acrt_top
    import acrt_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic global_irq_enable,
    input wire logic irq_vector_taken,
    output logic done_irq,
    input wire acrt_trig_s trig_flags,
    input wire acrt_conv_s conv_in,
    output logic conv_start,
    output logic converter_on,
    output logic converter_clk,
    output logic bipolar_mode,
    output logic comparator_mux_enable,
    input wire logic [7:0] pin_in,
    output logic [7:0] pin_input_off_bits,
    output logic [7:0] pin_read
);

    // ------------------------------------------------------------
    // functions
    // ------------------------------------------------------------

    // half period of converter clock, minus one, in system clocks
    function automatic logic [6:0] div_half(input logic [2:0] code);
        logic [6:0] h;
        h = 7'h00;
        case (code)
            3'h0: h = 7'h00;
            3'h1: h = 7'h00;
            3'h2: h = 7'h01;
            3'h3: h = 7'h03;
            3'h4: h = 7'h07;
            3'h5: h = 7'h0F;
            3'h6: h = 7'h1F;
            3'h7: h = 7'h3F;
            default: h = 7'h00;
        endcase
        return h;
    endfunction : div_half

    function automatic logic trig_pick(input logic [2:0] code, input acrt_trig_s f, input logic done_flag);
        logic s;
        s = 1'b0;
        case (acrt_trig_e'(code))
            ACRT_TS_FREE: s = done_flag;
            ACRT_TS_COMP: s = f.comparator;
            ACRT_TS_EXT0: s = f.ext_int0;
            ACRT_TS_T0_CMPA: s = f.t0_cmp_a;
            ACRT_TS_T0_OVF: s = f.t0_ovf;
            ACRT_TS_T1_CMPB: s = f.t1_cmp_b;
            ACRT_TS_T1_OVF: s = f.t1_ovf;
            ACRT_TS_T1_CAP: s = f.t1_capture;
            default: s = 1'b0;
        endcase
        return s;
    endfunction : trig_pick

    function automatic logic reg_hit(input logic [7:0] a, input logic [5:0] idx);
        return (a[7:2] == idx) && (a[1:0] == 2'h0);
    endfunction : reg_hit

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------

    logic en_q;
    logic busy_q;
    logic ate_q;
    logic flag_q;
    logic ie_q;
    logic [2:0] ps_q;
    logic [7:0] ctlb_q;
    logic [7:0] didr_q;
    logic [9:0] result_q;
    logic lock_q;

    logic [7:0] ctla_rd;
    logic [7:0] res_lo;
    logic [7:0] res_hi;
    logic [7:0] rd_byte;
    logic unmapped;
    logic acc_done;
    logic wr_a;
    logic wr_b;
    logic wr_didr;
    logic rd_lo;
    logic rd_hi;
    logic left_adjust;
    logic [2:0] trig_code;
    logic start_sw;
    logic trig_edge;
    logic start_now;
    logic result_load;
    logic flag_clear;
    logic [9:0] fmt_value;

    assign left_adjust = ctlb_q[`ACRT_B_LAR];
    assign trig_code = ctlb_q[`ACRT_B_TS_HI:`ACRT_B_TS_LO];
    assign acc_done = psel && penable && pready;
    assign wr_a = acc_done && pwrite && pstrb[0] && reg_hit(paddr, `ACRT_IDX_CTLA);
    assign wr_b = acc_done && pwrite && pstrb[0] && reg_hit(paddr, `ACRT_IDX_CTLB);
    assign wr_didr = acc_done && pwrite && pstrb[0] && reg_hit(paddr, `ACRT_IDX_DIDR);
    assign rd_lo = acc_done && !pwrite && reg_hit(paddr, `ACRT_IDX_RESL);
    assign rd_hi = acc_done && !pwrite && reg_hit(paddr, `ACRT_IDX_RESH);

    // ------------------------------------------------------------
    // result presentation
    // ------------------------------------------------------------

    // layout follows left_adjust at read time
    always_comb
    begin
        if (left_adjust)
        begin
            res_hi = result_q[9:2];
            res_lo = {result_q[1:0], 6'h00};
        end
        else
        begin
            res_hi = {6'h00, result_q[9:8]};
            res_lo = result_q[7:0];
        end
    end

    assign ctla_rd = {en_q, busy_q, ate_q, flag_q, ie_q, ps_q};

    always_comb
    begin
        rd_byte = 8'h00;
        unmapped = 1'b0;
        if (reg_hit(paddr, `ACRT_IDX_CTLA))
        begin
            rd_byte = ctla_rd;
        end
        else if (reg_hit(paddr, `ACRT_IDX_CTLB))
        begin
            rd_byte = ctlb_q;
        end
        else if (reg_hit(paddr, `ACRT_IDX_DIDR))
        begin
            rd_byte = didr_q;
        end
        else if (reg_hit(paddr, `ACRT_IDX_RESL))
        begin
            rd_byte = res_lo;
        end
        else if (reg_hit(paddr, `ACRT_IDX_RESH))
        begin
            rd_byte = res_hi;
        end
        else
        begin
            unmapped = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // apb slave: no wait state, answer in first access cycle
    // ------------------------------------------------------------

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else if (clk_en)
        begin
            if (psel && !penable)
            begin
                pready <= 1'b1;
                pslverr <= unmapped;
                prdata <= (pwrite || unmapped) ? 32'h0000_0000 : {24'h00_0000, rd_byte};
            end
            else
            begin
                pready <= 1'b0;
                pslverr <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // control register a
    // ------------------------------------------------------------

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            en_q <= 1'(`ACRT_RST_CTLA >> `ACRT_A_EN);
            ate_q <= 1'b0;
            ie_q <= 1'b0;
            ps_q <= 3'h0;
        end
        else if (clk_en && wr_a)
        begin
            en_q <= pwdata[`ACRT_A_EN];
            ate_q <= pwdata[`ACRT_A_ATE];
            ie_q <= pwdata[`ACRT_A_IE];
            ps_q <= pwdata[`ACRT_A_PS_HI:`ACRT_A_PS_LO];
        end
    end

    assign flag_clear = (wr_a && pwdata[`ACRT_A_FLAG]) || irq_vector_taken;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            flag_q <= 1'b0;
        end
        else if (clk_en)
        begin
            if (result_load)
            begin
                flag_q <= 1'b1;
            end
            else if (flag_clear)
            begin
                flag_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // control register b and input disable
    // ------------------------------------------------------------

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctlb_q <= `ACRT_RST_CTLB;
            didr_q <= `ACRT_RST_DIDR;
        end
        else if (clk_en)
        begin
            if (wr_b)
            begin
                ctlb_q <= pwdata[7:0];
            end
            if (wr_didr)
            begin
                didr_q <= pwdata[7:0];
            end
        end
    end

    // ------------------------------------------------------------
    // auto trigger
    // ------------------------------------------------------------

    logic trig_prev_q;
    logic [2:0] code_prev_q;
    logic trig_now;

    assign trig_now = trig_pick(trig_code, trig_flags, flag_q);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            trig_prev_q <= 1'b0;
            code_prev_q <= 3'h0;
        end
        else if (clk_en)
        begin
            trig_prev_q <= trig_now;
            code_prev_q <= trig_code;
        end
    end

    // rising edge of selected flag; covers reselect
    // no edge on switch to free running; gated by ate
    assign trig_edge = ate_q && trig_now && !trig_prev_q
                       && !((trig_code == 3'(ACRT_TS_FREE)) && (code_prev_q != trig_code));
    assign start_sw = wr_a && pwdata[`ACRT_A_START];
    assign start_now = (start_sw && pwdata[`ACRT_A_EN]) || (trig_edge && en_q);

    // ------------------------------------------------------------
    // conversion tracking and result register
    // ------------------------------------------------------------

    always_comb
    begin
        if (ctlb_q[`ACRT_B_BIN])
        begin
            fmt_value = conv_in.negative ? 10'(-{1'b0, conv_in.magnitude[9:1]}) : {1'b0, conv_in.magnitude[9:1]};
        end
        else
        begin
            fmt_value = conv_in.negative ? `ACRT_FULL_SCALE : conv_in.magnitude;
        end
    end

    assign result_load = conv_in.done && busy_q && !lock_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            busy_q <= 1'b0;
            conv_start <= 1'b0;
        end
        else if (clk_en)
        begin
            conv_start <= start_now && !busy_q;
            if (wr_a && !pwdata[`ACRT_A_EN])
            begin
                busy_q <= 1'b0;
            end
            else if (start_now)
            begin
                busy_q <= 1'b1;
            end
            else if (conv_in.done)
            begin
                busy_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            result_q <= `ACRT_RST_RES;
        end
        else if (clk_en && result_load)
        begin
            result_q <= fmt_value;
        end
    end

    // low read locks until high read
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lock_q <= 1'b0;
        end
        else if (clk_en)
        begin
            if (rd_hi)
            begin
                lock_q <= 1'b0;
            end
            else if (rd_lo)
            begin
                lock_q <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // interrupt, clock divider and plain outputs
    // ------------------------------------------------------------

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            done_irq <= 1'b0;
        end
        else if (clk_en)
        begin
            done_irq <= (result_load || (flag_q && !flag_clear)) && ie_q && global_irq_enable;
        end
    end

    logic [6:0] div_cnt_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            div_cnt_q <= 7'h00;
            converter_clk <= 1'b0;
        end
        else if (clk_en)
        begin
            if (div_cnt_q >= div_half(ps_q))
            begin
                div_cnt_q <= 7'h00;
                converter_clk <= !converter_clk;
            end
            else
            begin
                div_cnt_q <= div_cnt_q + 7'h01;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            converter_on <= 1'b0;
            bipolar_mode <= 1'b0;
            comparator_mux_enable <= 1'b0;
            pin_input_off_bits <= 8'h00;
        end
        else if (clk_en)
        begin
            converter_on <= en_q;
            bipolar_mode <= ctlb_q[`ACRT_B_BIN];
            comparator_mux_enable <= ctlb_q[`ACRT_B_COMPARATOR_MUX_ENABLE];
            pin_input_off_bits <= didr_q;
        end
    end

    // pad synchroniser: change accepted when stages two and three agree
    logic [7:0] pin_s1_q;
    logic [7:0] pin_s2_q;
    logic [7:0] pin_s3_q;
    logic [7:0] pin_ok_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_s1_q <= 8'h00;
            pin_s2_q <= 8'h00;
            pin_s3_q <= 8'h00;
            pin_ok_q <= 8'h00;
        end
        else if (clk_en)
        begin
            pin_s1_q <= pin_in;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
            pin_ok_q <= (pin_s2_q & pin_s3_q) | (pin_ok_q & (pin_s2_q | pin_s3_q));
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_read <= 8'h00;
        end
        else if (clk_en)
        begin
            pin_read <= pin_ok_q & ~didr_q;
        end
    end

endmodule : acrt_top

/* acrt_sva.sv */
// checker on the ports of acrt_top
// assumes: bound from the testbench top file, one clock domain
`timescale 1ns/10ps

module acrt_sva
(
    input logic pclk,
    input logic presetn,
    input logic clk_en,
    input logic psel,
    input logic penable,
    input logic [31:0] prdata,
    input logic pready,
    input logic pslverr,
    input logic global_irq_enable,
    input logic done_irq,
    input logic conv_start,
    input logic [7:0] pin_input_off_bits,
    input logic [7:0] pin_read
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // ----
    // bus answer
    // ----
    sequence s_setup;
        psel && !penable && clk_en;
    endsequence

    sequence s_access;
        clk_en;
    endsequence

    a_ready_after_setup: assert property (s_setup ##1 s_access |-> pready)
        else $error("no pready after setup");
    a_ready_one_cycle: assert property (pready && clk_en |=> !pready)
        else $error("pready longer than one cycle");
    a_error_with_ready: assert property (pslverr |-> pready && psel && penable)
        else $error("pslverr outside an answer");
    a_read_upper_zero: assert property (pready |-> prdata[31:8] == 24'h000000)
        else $error("read data upper bits set");
    a_error_data_zero: assert property (pslverr |-> prdata == 32'h00000000)
        else $error("refused access returned data");

    // ----
    // interrupt, start and pins
    // ----
    a_irq_needs_global: assert property (done_irq && $past(clk_en) |-> $past(global_irq_enable))
        else $error("interrupt without global enable");
    a_start_one_pulse: assert property (conv_start && clk_en |=> !conv_start)
        else $error("start pulse too long");
    a_pin_read_masked: assert property ($stable(pin_input_off_bits) ##1 $stable(pin_input_off_bits)
        |-> (pin_read & pin_input_off_bits) == 8'h00)
        else $error("disabled pin reads one");
endmodule : acrt_sva

/* acrt_tb_top.sv */
// self-checking testbench for the converter control block
// assumes: acrt_pkg and acrt_sva compiled first; bus master drives apb
`timescale 1ns/10ps
`include "acrt_cfg.svh"

module acrt_tb_top
    import acrt_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic clk_en = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic global_irq_enable = 1'b1;
    logic irq_vector_taken = 1'b0;
    acrt_trig_s trig_flags = '0;
    acrt_conv_s conv_in = '0;
    logic [7:0] pin_in = 8'h00;
    logic [31:0] prdata;
    logic pready, pslverr, done_irq, conv_start, converter_on, converter_clk;
    logic bipolar_mode, comparator_mux_enable;
    logic [7:0] pin_input_off_bits, pin_read;
    int n_mismatch = 0;
    int n_tests = 0;
    int n_start = 0;

    always #2 pclk = ~pclk;

    acrt_top uut
    (
        .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .global_irq_enable(global_irq_enable),
        .irq_vector_taken(irq_vector_taken), .done_irq(done_irq), .trig_flags(trig_flags),
        .conv_in(conv_in), .conv_start(conv_start), .converter_on(converter_on),
        .converter_clk(converter_clk), .bipolar_mode(bipolar_mode),
        .comparator_mux_enable(comparator_mux_enable), .pin_in(pin_in),
        .pin_input_off_bits(pin_input_off_bits), .pin_read(pin_read)
    );

    always @(posedge pclk)
        if (conv_start === 1'b1)
            n_start++;

    // ----
    // tasks
    // ----
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic xfer(input logic wr, input logic [5:0] idx, input logic [7:0] wd,
                        output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h000000, wd};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
        begin
            @(posedge pclk);
            n++;
        end
        chk("wait states", 32'h0, n);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer

    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        logic [31:0] r;
        logic e;
        xfer(1'b1, idx, d, r, e);
    endtask : wr

    task automatic rdc(input string name, input logic [5:0] idx, input logic [7:0] exp);
        logic [31:0] r;
        logic e;
        xfer(1'b0, idx, 8'h00, r, e);
        chk(name, {24'h000000, exp}, r);
    endtask : rdc

    task automatic conv(input logic [9:0] mag, input logic neg);
        @(posedge pclk);
        conv_in <= '{done: 1'b1, negative: neg, magnitude: mag};
        @(posedge pclk);
        conv_in.done <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask : conv

    task automatic starts(input string name, input int s0, input int exp);
        repeat (4) @(posedge pclk);
        chk(name, exp, n_start - s0);
    endtask : starts

    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : stop_test

    initial
    begin
        #200000;
        n_mismatch++;
        stop_test();
    end

    // ----
    // tests
    // ----
    initial
    begin
        int c, cyc, t0, rises, s0;
        logic last;
        logic [31:0] r;
        logic e;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge presetn);
        rdc("didr rst", `ACRT_IDX_DIDR, 8'h00);
        rdc("ctlb rst", `ACRT_IDX_CTLB, 8'h00);
        rdc("resl rst", `ACRT_IDX_RESL, 8'h00);
        rdc("resh rst", `ACRT_IDX_RESH, 8'h00);
        rdc("ctla rst", `ACRT_IDX_CTLA, 8'h00);
        xfer(1'b0, 6'h02, 8'h00, r, e);
        chk("unmapped err", 32'h1, {31'h0, e});
        chk("unmapped data", 32'h0, r);
        wr(`ACRT_IDX_CTLB, 8'h08);
        rdc("stored bit", `ACRT_IDX_CTLB, 8'h08);
        $display("test registers done");
        for (c = 0; c < 8; c++)
        begin
            wr(`ACRT_IDX_CTLA, 8'h80 | c[7:0]);
            cyc = 0;
            rises = 0;
            t0 = 0;
            last = converter_clk;
            while (rises < 3 && cyc < 600)
            begin
                @(posedge pclk);
                cyc++;
                if (converter_clk === 1'b1 && last === 1'b0)
                begin
                    rises++;
                    if (rises == 2)
                        t0 = cyc;
                end
                last = converter_clk;
            end
            chk("divider", (c < 2) ? 2 : (1 << c), cyc - t0);
        end
        chk("converter on", 32'h1, {31'h0, converter_on});
        // clock enable low must freeze the divider and the bus answer
        clk_en <= 1'b0;
        @(posedge pclk);
        last = converter_clk;
        repeat (200) @(posedge pclk);
        chk("frozen clk", {31'h0, last}, {31'h0, converter_clk});
        chk("frozen ready", 32'h0, {31'h0, pready});
        clk_en <= 1'b1;
        $display("test divider done");
        s0 = n_start;
        wr(`ACRT_IDX_CTLA, 8'hC8);
        starts("start write", s0, 1);
        conv(10'h2A5, 1'b0);
        rdc("flag set", `ACRT_IDX_CTLA, 8'h98);
        chk("irq on", 32'h1, {31'h0, done_irq});
        global_irq_enable <= 1'b0;
        repeat (3) @(posedge pclk);
        chk("irq gated", 32'h0, {31'h0, done_irq});
        global_irq_enable <= 1'b1;
        rdc("right low", `ACRT_IDX_RESL, 8'hA5);
        rdc("right high", `ACRT_IDX_RESH, 8'h02);
        wr(`ACRT_IDX_CTLA, 8'h98);
        rdc("flag clear", `ACRT_IDX_CTLA, 8'h88);
        chk("irq off", 32'h0, {31'h0, done_irq});
        wr(`ACRT_IDX_CTLB, 8'h10);
        rdc("left low", `ACRT_IDX_RESL, 8'h40);
        rdc("left high", `ACRT_IDX_RESH, 8'hA9);
        wr(`ACRT_IDX_CTLB, 8'h00);
        rdc("relayout low", `ACRT_IDX_RESL, 8'hA5);
        rdc("relayout high", `ACRT_IDX_RESH, 8'h02);
        $display("test result layout done");
        rdc("lock low", `ACRT_IDX_RESL, 8'hA5);
        wr(`ACRT_IDX_CTLA, 8'hC0);
        conv(10'h155, 1'b0);
        rdc("no flag", `ACRT_IDX_CTLA, 8'h80);
        rdc("held high", `ACRT_IDX_RESH, 8'h02);
        rdc("dropped low", `ACRT_IDX_RESL, 8'hA5);
        rdc("dropped high", `ACRT_IDX_RESH, 8'h02);
        wr(`ACRT_IDX_CTLA, 8'hC0);
        conv(10'h123, 1'b1);
        rdc("sat low", `ACRT_IDX_RESL, 8'hFF);
        rdc("sat high", `ACRT_IDX_RESH, 8'h03);
        irq_vector_taken <= 1'b1;
        @(posedge pclk);
        irq_vector_taken <= 1'b0;
        rdc("vector clear", `ACRT_IDX_CTLA, 8'h80);
        wr(`ACRT_IDX_CTLB, 8'hC0);
        wr(`ACRT_IDX_CTLA, 8'hC0);
        conv(10'h0C8, 1'b1);
        chk("bipolar out", 32'h1, {31'h0, bipolar_mode});
        chk("mux out", 32'h1, {31'h0, comparator_mux_enable});
        rdc("bip low", `ACRT_IDX_RESL, 8'h9C);
        rdc("bip high", `ACRT_IDX_RESH, 8'h03);
        wr(`ACRT_IDX_CTLB, 8'h00);
        $display("test lock and formats done");
        wr(`ACRT_IDX_CTLA, 8'hB0);
        for (c = 1; c < 8; c++)
        begin
            wr(`ACRT_IDX_CTLB, c[7:0]);
            s0 = n_start;
            trig_flags <= 7'h40 >> (c - 1);
            starts("trigger code", s0, 1);
            conv(10'h001, 1'b0);
            trig_flags <= '0;
        end
        wr(`ACRT_IDX_CTLA, 8'h90);
        wr(`ACRT_IDX_CTLB, 8'h01);
        s0 = n_start;
        trig_flags <= 7'h40;
        starts("auto off", s0, 0);
        trig_flags <= '0;
        wr(`ACRT_IDX_CTLA, 8'hA0);
        s0 = n_start;
        trig_flags <= 7'h20;
        wr(`ACRT_IDX_CTLB, 8'h02);
        starts("reselect", s0, 1);
        conv(10'h001, 1'b0);
        trig_flags <= '0;
        s0 = n_start;
        wr(`ACRT_IDX_CTLB, 8'h00);
        starts("free select", s0, 0);
        $display("test triggers done");
        pin_in <= 8'hFF;
        wr(`ACRT_IDX_DIDR, 8'h5A);
        repeat (8) @(posedge pclk);
        chk("pin read", 32'hA5, {24'h0, pin_read});
        chk("pin off", 32'h5A, {24'h0, pin_input_off_bits});
        rdc("didr back", `ACRT_IDX_DIDR, 8'h5A);
        $display("test pins done");
        stop_test();
    end
endmodule : acrt_tb_top

bind acrt_top acrt_sva u_sva
(
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .global_irq_enable(global_irq_enable), .done_irq(done_irq), .conv_start(conv_start),
    .pin_input_off_bits(pin_input_off_bits), .pin_read(pin_read)
);
